//--- logic/vir_regs.svh
// Register offsets, field positions, reset values and exception numbers of the interrupt router.
`ifndef VIR_REGS_SVH
`define VIR_REGS_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define VIR_OFS_ENABLE     8'h00
`define VIR_OFS_SRC_LO     8'h04
`define VIR_OFS_SRC_HI     8'h08
`define VIR_OFS_CTRL       8'h0C
`define VIR_OFS_PEND_IRQ   8'h10
`define VIR_OFS_SYS_STAT   8'h14
`define VIR_OFS_ACT_IRQ    8'h18
`define VIR_OFS_PRIO_BASE  8'h20
`define VIR_PRIO_WORDS     12
// ****************************************************************
// Control register fields
// ****************************************************************
`define VIR_CTRL_GROUP_LSB 0
`define VIR_CTRL_BITS_LSB  4
`define VIR_CTRL_MEM_EN    8
`define VIR_CTRL_BUS_EN    9
`define VIR_CTRL_USE_EN    10
`define VIR_CTRL_NMI_EN    16
`define VIR_CTRL_NMI_LSB   18
`define VIR_CTRL_RESET     32'h0000_0080
`define VIR_SYS_PEND_DEFER 0
// ****************************************************************
// Exception numbers, sources and limits
// ****************************************************************
`define VIR_EXC_RESET      6'h01
`define VIR_EXC_NMI        6'h02
`define VIR_EXC_HARD       6'h03
`define VIR_EXC_MEM        6'h04
`define VIR_EXC_BUS        6'h05
`define VIR_EXC_USAGE      6'h06
`define VIR_EXC_SUPV_CALL  6'h0B
`define VIR_EXC_DEBUG      6'h0C
`define VIR_EXC_DEFER      6'h0E
`define VIR_EXC_TICK       6'h0F
`define VIR_EXC_IRQ0       6'h10
`define VIR_NUM_EXC        48
`define VIR_NUM_IRQ        32
`define VIR_DMA_PER_GROUP  16
`define VIR_SYS_IMPL       16'hD87E
`define VIR_FIXED_IMPL     32'hE3E0_BFFB
`define VIR_SP_OFFSET      10'h000
`define VIR_PRIO_MIN       4'h3
`define VIR_PRIO_MAX       4'h8
`define VIR_SRC_FIXED      2'h0
`define VIR_SRC_DMA        2'h1
`define VIR_SRC_LOGIC      2'h2
`define VIR_HI_FIXED       9'h003
`define VIR_HI_NONE        9'h1FF
`endif

//--- logic/vir_pkg.sv
// Types shared by the interrupt router.
`default_nettype none
package vir_pkg;
  typedef enum logic [2:0] {
    VIR_ST_SP_FETCH = 3'h1,
    VIR_ST_IDLE     = 3'h2,
    VIR_ST_REQ      = 3'h4
  } vir_state_t;
  typedef logic [16:0] vir_key_t;
endpackage
`default_nettype wire

//--- logic/vir_router.sv
// Vectored interrupt router: source selection, priority arbitration and core entry/exit handshake.
`timescale 1ns/1ps
`default_nettype none
`include "vir_regs.svh"
module vir_router (
  // Clock and reset.
  input  wire logic        I_CLOCK,
  input  wire logic        I_ARST_N,
  // Register port.
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [31:0] I_WR_DATA,
  input  wire logic        I_WR_STB,
  input  wire logic        I_RD_STB,
  output logic      [31:0] O_RD_DATA,
  // Interrupt sources.
  input  wire logic [31:0] I_FIXED_IRQ,
  input  wire logic [15:0] I_DMA_DONE_GROUP0,
  input  wire logic [15:0] I_DMA_DONE_GROUP1,
  input  wire logic [31:0] I_LOGIC_IRQ,
  input  wire logic [7:0]  I_NMI_PINS,
  // System exception events from the core.
  input  wire logic        I_MEM_PROT_FAULT,
  input  wire logic        I_BUS_FAULT,
  input  wire logic        I_USAGE_FAULT,
  input  wire logic        I_SUPERVISOR_CALL,
  input  wire logic        I_DEBUG_MON,
  input  wire logic        I_SYS_TICK,
  // Core handshake.
  input  wire logic        I_EXC_ACK,
  input  wire logic        I_EXC_RETURN,
  output logic             O_EXC_REQ,
  output logic      [5:0]  O_EXC_NUM,
  output logic      [9:0]  O_VEC_OFFSET,
  output logic             O_SP_LOAD,
  output logic             O_STATE_SAVE,
  output logic             O_STATE_RESTORE,
  output logic             O_TAIL_CHAIN
);
  // ****************************************************************
  // Configuration and run state
  // ****************************************************************
  logic [31:0]          enable_q;
  logic [63:0]          src_sel_q;
  logic [31:0]          ctrl_q;
  logic [7:0]           prio_q [`VIR_NUM_EXC];
  logic [47:0]          pend_q;
  logic [47:0]          active_q;
  logic [31:0]          src_prev_q;
  logic [7:0]           nmi_s1_q;
  logic [7:0]           nmi_s2_q;
  logic                 nmi_prev_q;
  logic                 ret_q;
  logic                 chain_q;
  vir_pkg::vir_state_t  state_q;
  logic [31:0]          src_now;
  logic [47:0]          pend_set;
  logic [47:0]          pend_clr;
  logic                 nmi_now;
  logic [3:0]           prio_bits;
  logic [7:0]           prio_mask;
  logic [3:0]           grp_shift;
  logic                 cand_ok;
  logic [5:0]           cand_num;
  logic [8:0]           cand_hi;
  logic                 run_ok;
  logic [5:0]           run_num;
  logic [8:0]           run_hi;
  logic                 preempt;
  logic                 take;
  localparam logic [31:0] fixed_impl = `VIR_FIXED_IMPL;

  // Implemented width is clamped so a bad write cannot leave zero levels.
  always_comb begin
    prio_bits = ctrl_q[`VIR_CTRL_BITS_LSB +: 4];
    if (prio_bits < `VIR_PRIO_MIN) begin
      prio_bits = `VIR_PRIO_MIN;
    end else if (prio_bits > `VIR_PRIO_MAX) begin
      prio_bits = `VIR_PRIO_MAX;
    end
    prio_mask = 8'hFF << (`VIR_PRIO_MAX - prio_bits);
    grp_shift = {1'b0, ctrl_q[`VIR_CTRL_GROUP_LSB +: 3]} + 4'h1;
  end

  // Sort key: preempting level on top, full level below it; fixed ones sit on levels 0 to 2 so they outrank all configurable ones.
  function automatic vir_pkg::vir_key_t key_of(input logic [5:0] num);
    logic [7:0] lvl;
    lvl = prio_q[num] & prio_mask;
    if (num == `VIR_EXC_RESET || num == `VIR_EXC_NMI || num == `VIR_EXC_HARD) begin
      key_of = {3'h0, num - 6'h01, 8'h00};
    end else begin
      key_of = {9'(lvl >> grp_shift) + `VIR_HI_FIXED, lvl};
    end
  endfunction

  // Strict compare in ascending order keeps the lower number on ties.
  function automatic logic [15:0] pick(input logic [47:0] set);
    vir_pkg::vir_key_t best;
    logic              found;
    logic [5:0]        num;
    best  = '1;
    found = 1'b0;
    num   = 6'h00;
    for (int e = 1; e < `VIR_NUM_EXC; e++) begin
      if (set[e] && (!found || key_of(6'(e)) < best)) begin
        best  = key_of(6'(e));
        found = 1'b1;
        num   = 6'(e);
      end
    end
    pick = {found, num, best[16:8]};
  endfunction

  // ****************************************************************
  // Source selection
  // ****************************************************************
  // Each vector picks one line; code 3 is left unconnected.
  generate
    for (genvar v = 0; v < `VIR_NUM_IRQ; v++) begin : g_src
      logic dma_line;
      assign dma_line = (v < `VIR_DMA_PER_GROUP) ? I_DMA_DONE_GROUP0[v % `VIR_DMA_PER_GROUP]
                                                 : I_DMA_DONE_GROUP1[v % `VIR_DMA_PER_GROUP];
      always_comb begin
        unique case (src_sel_q[2*v +: 2])
          `VIR_SRC_FIXED: src_now[v] = I_FIXED_IRQ[v] & fixed_impl[v];
          `VIR_SRC_DMA:   src_now[v] = dma_line;
          `VIR_SRC_LOGIC: src_now[v] = I_LOGIC_IRQ[v];
          default:        src_now[v] = 1'b0;
        endcase
      end
    end
  endgenerate

  // Pins are asynchronous, so the selection reads only the second stage.
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      nmi_s1_q   <= 8'h00;
      nmi_s2_q   <= 8'h00;
      nmi_prev_q <= 1'b0;
    end else begin
      nmi_s1_q   <= I_NMI_PINS;
      nmi_s2_q   <= nmi_s1_q;
      nmi_prev_q <= nmi_now;
    end
  end
  assign nmi_now = ctrl_q[`VIR_CTRL_NMI_EN] & nmi_s2_q[ctrl_q[`VIR_CTRL_NMI_LSB +: 3]];

  // ****************************************************************
  // Pending state
  // ****************************************************************
  // A fault whose handler cannot run now pends hard fault instead.
  always_comb begin
    pend_set = '0;
    pend_set[`VIR_NUM_EXC-1:`VIR_NUM_EXC-`VIR_NUM_IRQ] = src_now & ~src_prev_q;
    pend_set[`VIR_EXC_NMI] = nmi_now & ~nmi_prev_q;
    if (I_MEM_PROT_FAULT) begin
      if (ctrl_q[`VIR_CTRL_MEM_EN] && key_of(`VIR_EXC_MEM) >> 8 < run_hi) begin
        pend_set[`VIR_EXC_MEM] = 1'b1;
      end else begin
        pend_set[`VIR_EXC_HARD] = 1'b1;
      end
    end
    if (I_BUS_FAULT) begin
      if (ctrl_q[`VIR_CTRL_BUS_EN] && key_of(`VIR_EXC_BUS) >> 8 < run_hi) begin
        pend_set[`VIR_EXC_BUS] = 1'b1;
      end else begin
        pend_set[`VIR_EXC_HARD] = 1'b1;
      end
    end
    if (I_USAGE_FAULT) begin
      if (ctrl_q[`VIR_CTRL_USE_EN] && key_of(`VIR_EXC_USAGE) >> 8 < run_hi) begin
        pend_set[`VIR_EXC_USAGE] = 1'b1;
      end else begin
        pend_set[`VIR_EXC_HARD] = 1'b1;
      end
    end
    pend_set[`VIR_EXC_SUPV_CALL] = I_SUPERVISOR_CALL;
    pend_set[`VIR_EXC_DEBUG] = I_DEBUG_MON;
    pend_set[`VIR_EXC_TICK]  = I_SYS_TICK;
    pend_set[`VIR_EXC_DEFER] = I_WR_STB && I_ADDR == `VIR_OFS_SYS_STAT && I_WR_DATA[`VIR_SYS_PEND_DEFER];
    pend_clr = '0;
    if (take) begin
      pend_clr[O_EXC_NUM] = 1'b1;
    end
  end

  // A new event in the cycle it is taken wins over the clear.
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pend_q     <= 48'h0000_0000_0002; // Reset exception waits from the start.
      src_prev_q <= 32'h0000_0000;
    end else begin
      pend_q     <= (pend_q & ~pend_clr) | pend_set;
      src_prev_q <= src_now;
    end
  end

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  logic [47:0] eligible;
  always_comb begin
    eligible = pend_q & {enable_q, `VIR_SYS_IMPL};
    {cand_ok, cand_num, cand_hi} = pick(eligible);
    {run_ok, run_num, run_hi}    = pick(active_q);
    if (!run_ok) begin
      run_hi = `VIR_HI_NONE;
    end
    preempt = cand_ok && (cand_hi < run_hi);
  end
  assign take = (state_q == vir_pkg::VIR_ST_REQ) && I_EXC_ACK;

  // ****************************************************************
  // Core handshake
  // ****************************************************************
  // The number keeps following the best candidate until the core takes it.
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_q      <= vir_pkg::VIR_ST_SP_FETCH;
      O_EXC_REQ    <= 1'b0;
      O_EXC_NUM    <= 6'h00;
      O_VEC_OFFSET <= `VIR_SP_OFFSET;
      O_SP_LOAD    <= 1'b1;
    end else begin
      unique case (state_q)
        vir_pkg::VIR_ST_SP_FETCH: begin
          if (I_EXC_ACK) begin
            state_q   <= vir_pkg::VIR_ST_IDLE;
            O_SP_LOAD <= 1'b0;
          end
        end
        vir_pkg::VIR_ST_IDLE: begin
          if (preempt && !ret_q) begin
            state_q      <= vir_pkg::VIR_ST_REQ;
            O_EXC_REQ    <= 1'b1;
            O_EXC_NUM    <= cand_num;
            O_VEC_OFFSET <= {cand_num, 4'h0} >> 2;
          end
        end
        vir_pkg::VIR_ST_REQ: begin
          if (take || !preempt) begin
            state_q   <= vir_pkg::VIR_ST_IDLE;
            O_EXC_REQ <= 1'b0;
          end else begin
            O_EXC_NUM    <= cand_num;
            O_VEC_OFFSET <= {cand_num, 4'h0} >> 2;
          end
        end
      endcase
    end
  end

  // Entry saves state unless chained; exit restores unless another is due.
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      active_q        <= 48'h0000_0000_0000;
      ret_q           <= 1'b0;
      chain_q         <= 1'b0;
      O_STATE_SAVE    <= 1'b0;
      O_STATE_RESTORE <= 1'b0;
      O_TAIL_CHAIN    <= 1'b0;
    end else begin
      O_STATE_SAVE    <= take && !chain_q;
      O_STATE_RESTORE <= ret_q && !preempt;
      O_TAIL_CHAIN    <= ret_q && preempt;
      ret_q           <= I_EXC_RETURN && run_ok;
      if (take) begin
        active_q[O_EXC_NUM] <= 1'b1;
        chain_q             <= 1'b0;
      end else if (ret_q) begin
        chain_q <= preempt;
      end
      if (I_EXC_RETURN && run_ok) begin
        active_q[run_num] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Register port
  // ****************************************************************
  // Fixed-priority entries ignore writes; their level comes from the key.
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      enable_q  <= 32'h0000_0000;
      src_sel_q <= 64'h0000_0000_0000_0000;
      ctrl_q    <= `VIR_CTRL_RESET;
      for (int e = 0; e < `VIR_NUM_EXC; e++) begin
        prio_q[e] <= 8'h00;
      end
    end else if (I_WR_STB) begin
      unique case (I_ADDR)
        `VIR_OFS_ENABLE: enable_q        <= I_WR_DATA;
        `VIR_OFS_SRC_LO: src_sel_q[31:0]  <= I_WR_DATA;
        `VIR_OFS_SRC_HI: src_sel_q[63:32] <= I_WR_DATA;
        `VIR_OFS_CTRL:   ctrl_q          <= I_WR_DATA;
        default: begin
          for (int e = 4; e < `VIR_NUM_EXC; e++) begin
            if (I_ADDR == `VIR_OFS_PRIO_BASE + 8'((e / 4) * 4)) begin
              prio_q[e] <= I_WR_DATA[8*(e%4) +: 8];
            end
          end
        end
      endcase
    end
  end

  // Read data stand for the one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RD_DATA <= 32'h0000_0000;
    end else begin
      O_RD_DATA <= 32'h0000_0000;
      if (I_RD_STB) begin
        unique case (I_ADDR)
          `VIR_OFS_ENABLE:   O_RD_DATA <= enable_q;
          `VIR_OFS_SRC_LO:   O_RD_DATA <= src_sel_q[31:0];
          `VIR_OFS_SRC_HI:   O_RD_DATA <= src_sel_q[63:32];
          `VIR_OFS_CTRL:     O_RD_DATA <= ctrl_q;
          `VIR_OFS_PEND_IRQ: O_RD_DATA <= pend_q[47:16];
          `VIR_OFS_SYS_STAT: O_RD_DATA <= {pend_q[15:0], 10'h000, run_num};
          `VIR_OFS_ACT_IRQ:  O_RD_DATA <= active_q[47:16];
          default: begin
            for (int w = 0; w < `VIR_PRIO_WORDS; w++) begin
              if (I_ADDR == `VIR_OFS_PRIO_BASE + 8'(w * 4)) begin
                O_RD_DATA <= {prio_q[4*w+3] & prio_mask, prio_q[4*w+2] & prio_mask,
                              prio_q[4*w+1] & prio_mask, prio_q[4*w] & prio_mask};
              end
            end
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_vec_offset: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    O_EXC_REQ |-> O_VEC_OFFSET == {O_EXC_NUM, 2'b00}) else $error("vector offset mismatch");
  chk_sp_first: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    O_SP_LOAD |-> !O_EXC_REQ && O_VEC_OFFSET == `VIR_SP_OFFSET) else $error("stack pointer fetch wrong");
  chk_preempt_gate: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    $rose(O_EXC_REQ) |-> $past(preempt)) else $error("request without preemption");
  chk_late_arrival: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    state_q == vir_pkg::VIR_ST_REQ && !I_EXC_ACK && preempt |=> O_EXC_NUM == $past(cand_num))
    else $error("late arrival missed");
  chk_escalate: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    I_MEM_PROT_FAULT && !ctrl_q[`VIR_CTRL_MEM_EN] |=> pend_q[`VIR_EXC_HARD]) else $error("no escalation");
  chk_dma_route: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    src_sel_q[1:0] == `VIR_SRC_DMA && I_DMA_DONE_GROUP0[0] && !src_prev_q[0] |=> pend_q[16])
    else $error("dma source not pended");
  chk_state_save: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    take && !chain_q |=> O_STATE_SAVE ##1 !O_STATE_SAVE) else $error("state save missing");
  chk_tail_chain: assert property (@(posedge I_CLOCK) disable iff (!I_ARST_N)
    ret_q && preempt |=> O_TAIL_CHAIN && !O_STATE_RESTORE) else $error("tail chain missing");
endmodule
`default_nettype wire

//--- test/vir_core_model.sv
// Behavioural model of the processor core that answers the interrupt router.
`timescale 1ns/1ps
`default_nettype none
module vir_core_model (
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Requests and pulses from the router.
  input  wire logic       i_req,
  input  wire logic       i_sp_load,
  input  wire logic [5:0] i_num,
  input  wire logic [9:0] i_ofs,
  input  wire logic       i_save,
  input  wire logic       i_restore,
  input  wire logic       i_tail,
  // Commands from the bench.
  input  wire logic       i_stall,
  input  wire logic       i_ret_cmd,
  // Answers to the router.
  output logic            o_ack,
  output logic            o_ret
);
  int         n_ack;
  int         n_restore;
  int         n_tail;
  int         depth;
  logic [5:0] num_log [64];
  logic [9:0] ofs_log [64];
  logic       save_log [64];

  // Acks one cycle after a request shows, or later while stalled, so late arrival can be provoked.
  // A return is only issued while a handler is active, as a real core would.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ack     <= 1'b0;
      o_ret     <= 1'b0;
      n_ack     <= 0;
      n_restore <= 0;
      n_tail    <= 0;
      depth     <= 0;
    end else begin
      o_ack <= !o_ack && !i_stall && (i_req || i_sp_load);
      o_ret <= i_ret_cmd && (depth > 0) && !o_ret;
      depth <= depth + ((o_ack && !i_sp_load) ? 1 : 0) - (o_ret ? 1 : 0);
      if (o_ack) begin
        num_log[n_ack]  <= i_num;
        ofs_log[n_ack]  <= i_ofs;  // Software keeps bit 0 of each table word set
        save_log[n_ack] <= 1'b0;
        n_ack           <= n_ack + 1;
      end
      if (i_save && n_ack > 0) begin
        save_log[n_ack - 1] <= 1'b1;
      end
      if (i_restore) begin
        n_restore <= n_restore + 1;
      end
      if (i_tail) begin
        n_tail <= n_tail + 1;
      end
    end
  end
endmodule
`default_nettype wire

//--- test/vectored_irq_source_router_bench.sv
// Self-checking bench for the vectored interrupt router.
`timescale 1ns/1ps
`default_nettype none
`include "vir_regs.svh"
module vectored_irq_source_router_bench;
  logic        clk;
  logic        rst_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [31:0] rdata;
  logic [31:0] fix_irq;
  logic [31:0] dma_irq;
  logic [31:0] lgc_irq;
  logic [7:0]  nmi_pins;
  logic [5:0]  flt;
  logic        ack;
  logic        ret;
  logic        req;
  logic [5:0]  num;
  logic [9:0]  ofs;
  logic        sp_load;
  logic        save;
  logic        restore;
  logic        tail;
  logic        stall;
  logic        ret_cmd;
  int          n_fail;
  int          checks;
  int          seen;
  int          k;
  int          j;
  int          p;
  int          v;
  logic [5:0]  own [6] = '{6'h04, 6'h05, 6'h06, 6'h0B, 6'h0C, 6'h0F};

  vir_router dut_u (
    .I_CLOCK(clk), .I_ARST_N(rst_n), .I_ADDR(addr), .I_WR_DATA(wdata), .I_WR_STB(wr_stb),
    .I_RD_STB(rd_stb), .O_RD_DATA(rdata), .I_FIXED_IRQ(fix_irq), .I_DMA_DONE_GROUP0(dma_irq[15:0]),
    .I_DMA_DONE_GROUP1(dma_irq[31:16]), .I_LOGIC_IRQ(lgc_irq), .I_NMI_PINS(nmi_pins),
    .I_MEM_PROT_FAULT(flt[0]), .I_BUS_FAULT(flt[1]), .I_USAGE_FAULT(flt[2]), .I_SUPERVISOR_CALL(flt[3]),
    .I_DEBUG_MON(flt[4]), .I_SYS_TICK(flt[5]), .I_EXC_ACK(ack), .I_EXC_RETURN(ret), .O_EXC_REQ(req),
    .O_EXC_NUM(num), .O_VEC_OFFSET(ofs), .O_SP_LOAD(sp_load), .O_STATE_SAVE(save),
    .O_STATE_RESTORE(restore), .O_TAIL_CHAIN(tail));

  vir_core_model core_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_sp_load(sp_load), .i_num(num), .i_ofs(ofs),
    .i_save(save), .i_restore(restore), .i_tail(tail), .i_stall(stall), .i_ret_cmd(ret_cmd),
    .o_ack(ack), .o_ret(ret));

  // ****************************************************************
  // Clock, watchdog and shared tasks
  // ****************************************************************
  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // A hang anywhere ends the run as a failure.
  initial begin
    #400000;
    n_fail++;
    wrap_up();
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are sampled just then.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, e, "read data");
  endtask

  // Kind 0 fixed, 1 DMA, 2 logic array, 3 nonmaskable pins; held two cycles for the pin synchroniser.
  task automatic raise(input int kind, input logic [31:0] m);
    @(posedge clk);
    case (kind)
      0: fix_irq <= m;
      1: dma_irq <= m;
      2: lgc_irq <= m;
      default: nmi_pins <= m[7:0];
    endcase
    repeat (2) @(posedge clk);
    fix_irq  <= '0;
    dma_irq  <= '0;
    lgc_irq  <= '0;
    nmi_pins <= '0;
  endtask

  task automatic fault(input int i);
    @(posedge clk);
    flt[i] <= 1'b1;
    @(posedge clk);
    flt[i] <= 1'b0;
  endtask

  // Waits for the next entry taken by the core and checks number, offset and state save.
  task automatic take(input logic [5:0] n, input logic s);
    int i;
    for (i = 0; i < 60 && core_u.n_ack <= seen; i++) @(posedge clk);
    if (core_u.n_ack <= seen) begin
      n_fail++;
      $display("mismatch at %0t: no entry taken", $time);
      wrap_up();
    end
    repeat (2) @(posedge clk);
    #1;
    chk(32'(core_u.num_log[seen]), 32'(n), "number");
    chk(32'(core_u.ofs_log[seen]), 32'({n, 2'h0}), "offset");
    chk(32'(core_u.save_log[seen]), 32'(s), "state save");
    seen++;
  endtask

  task automatic none;
    repeat (12) @(posedge clk);
    chk(32'(core_u.n_ack), 32'(seen), "unexpected entry");
  endtask

  task automatic leave(input int r, input int t);
    int r0;
    int t0;
    r0 = core_u.n_restore;
    t0 = core_u.n_tail;
    @(posedge clk);
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
    repeat (5) @(posedge clk);
    chk(32'(core_u.n_restore - r0), 32'(r), "restore");
    chk(32'(core_u.n_tail - t0), 32'(t), "tail chain");
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    addr = '0;
    wdata = '0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    fix_irq = '0;
    dma_irq = '0;
    lgc_irq = '0;
    nmi_pins = '0;
    flt = '0;
    stall = 1'b0;
    ret_cmd = 1'b0;
    n_fail = 0;
    checks = 0;
    repeat (8) @(posedge clk);
    #1;
    chk(32'(sp_load), 32'h1, "stack pointer fetch");
    chk(32'(ofs), 32'h0, "reset offset");
    @(posedge clk);
    rst_n <= 1'b1;
    rd(`VIR_OFS_CTRL, `VIR_CTRL_RESET);
    rd(`VIR_OFS_SRC_LO, 32'h0);
    rd(`VIR_OFS_SRC_HI, 32'h0);
    rd(8'h60, 32'h0);
    chk(32'(core_u.ofs_log[0]), 32'h0, "stack pointer offset");
    seen = 1;
    take(`VIR_EXC_RESET, 1'b1);
    leave(1, 0);
    wr(`VIR_OFS_ENABLE, 32'hFFFF_FFFF);
    raise(0, 32'h0000_0001);
    take(6'h10, 1'b1);
    leave(1, 0);
    raise(0, 32'h8000_0000);
    take(6'h2F, 1'b1);
    leave(1, 0);
    raise(0, 32'h1C1F_4004);
    none;
    rd(`VIR_OFS_PEND_IRQ, 32'h0);
    // DMA, then logic-array sources on the first and last vector of each group.
    for (k = 1; k < 4; k++) begin
      wr(`VIR_OFS_SRC_LO, k == 1 ? 32'h5555_5555 : (k == 2 ? 32'hAAAA_AAAA : 32'hFFFF_FFFF));
      wr(`VIR_OFS_SRC_HI, k == 1 ? 32'h5555_5555 : (k == 2 ? 32'hAAAA_AAAA : 32'hFFFF_FFFF));
      raise(0, 32'h0000_0009);
      none;
      for (j = 0; j < 4 && k < 3; j++) begin
        v = (j % 2) * 15 + (j / 2) * 16;
        raise(k, 32'h1 << v);
        take(6'(16 + v), 1'b1);
        leave(1, 0);
      end
    end
    raise(1, 32'hFFFF_FFFF);
    raise(2, 32'hFFFF_FFFF);
    none;
    wr(`VIR_OFS_SRC_LO, 32'h0);
    wr(`VIR_OFS_SRC_HI, 32'h0);
    // Late arrival of an equal-priority, lower-numbered vector while the core stalls.
    stall <= 1'b1;
    raise(0, 32'h0000_0020);
    raise(0, 32'h0000_0008);
    @(posedge clk);
    #1;
    chk(32'(num), 32'h13, "late arrival");
    stall <= 1'b0;
    take(6'h13, 1'b1);
    leave(0, 1);
    take(6'h15, 1'b0);
    leave(1, 0);
    wr(8'h30, 32'h8000_0000);
    rd(8'h30, 32'h8000_0000);
    raise(0, 32'h0000_0028);
    take(6'h15, 1'b1);
    leave(0, 1);
    take(6'h13, 1'b0);
    leave(1, 0);
    // Nesting happens only when the preempting part is strictly higher.
    for (p = 0; p < 2; p++) begin
      wr(`VIR_OFS_CTRL, p == 0 ? `VIR_CTRL_RESET : 32'h0000_0087);
      raise(0, 32'h0000_0008);
      take(6'h13, 1'b1);
      raise(0, 32'h0000_0020);
      if (p == 0) begin
        take(6'h15, 1'b1);
        leave(1, 0);
        leave(1, 0);
      end else begin
        none;
        leave(0, 1);
        take(6'h15, 1'b0);
        leave(1, 0);
      end
    end
    wr(`VIR_OFS_CTRL, 32'h0000_0030);
    wr(8'h30, 32'hFF00_0000);
    rd(8'h30, 32'hE000_0000);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0);
    // Faults with own handlers disabled, then enabled.
    for (p = 0; p < 2; p++) begin
      wr(`VIR_OFS_CTRL, p == 0 ? `VIR_CTRL_RESET : 32'h0000_0780);
      for (k = 0; k < 6; k++) begin
        fault(k);
        take((k < 3 && p == 0) ? `VIR_EXC_HARD : own[k], 1'b1);
        leave(1, 0);
      end
    end
    // An escalated fault must still preempt a running level-0 handler.
    raise(0, 32'h0000_0020);
    take(6'h15, 1'b1);
    rd(`VIR_OFS_ACT_IRQ, 32'h0000_0020);
    fault(0);
    take(`VIR_EXC_HARD, 1'b1);
    rd(`VIR_OFS_SYS_STAT, 32'h0000_0003);
    leave(1, 0);
    leave(1, 0);
    wr(`VIR_OFS_SYS_STAT, 32'h0000_0001);
    take(`VIR_EXC_DEFER, 1'b1);
    leave(1, 0);
    wr(`VIR_OFS_CTRL, 32'h000D_0080);
    raise(3, 32'h0000_0020);
    none;
    raise(3, 32'h0000_0008);
    take(`VIR_EXC_NMI, 1'b1);
    leave(1, 0);
    wr(`VIR_OFS_CTRL, 32'h000C_0080);
    raise(3, 32'h0000_0008);
    none;
    wrap_up();
  end
endmodule
`default_nettype wire
